// file: csc_adapter_model.sv
// Purpose: Behavioural adapter facing the channel sequencer tags.
// Assumes: The bench offers bytes by one-cycle pulses.
// Notes: A released inbound bus shows the inverse of its last byte.
`timescale 1ns/10ps
module csc_adapter_model (
  input wire logic i_clk,             // Clock.
  input wire logic i_reset_n,         // Reset, active low.
  input wire logic i_send,            // Pulse: offer a byte.
  input wire logic [7:0] i_byte,      // Byte offered.
  input wire logic i_operational_out, // Channel tag.
  input wire logic i_suppress_out,    // Channel tag.
  input wire logic i_address_out,     // Channel tag.
  input wire logic i_select_out,      // Channel tag.
  input wire logic i_hold_out,        // Channel tag.
  input wire logic i_service_out,     // Channel tag.
  input wire logic i_command_out,     // Channel tag.
  output logic o_operational_in,      // Adapter tag.
  output logic o_status_in,           // Adapter tag.
  output logic o_service_in,          // Adapter tag.
  output logic [7:0] o_bus_in,        // Inbound bus.
  output logic o_chain,               // Chaining seen at accept.
  output logic o_sys_rst              // System reset seen.
);
  logic [9:0] gap_r, rst_r;
  logic stop_r, acc_r;
  // One process reacts to the channel just after each rising edge.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {o_operational_in, o_status_in, o_service_in, stop_r} <= 4'h0;
      {o_chain, o_sys_rst, acc_r, gap_r, rst_r} <= 23'h000000;
      o_bus_in <= 8'h00;
    end else begin
      gap_r <= (i_address_out && !i_select_out && !i_hold_out) ?
        gap_r + 10'h001 : 10'h000;
      rst_r <= (i_operational_out || i_suppress_out) ? 10'h000 :
        rst_r + 10'h001;
      acc_r <= 1'b0;
      if (i_select_out && i_address_out && !acc_r) o_operational_in <= 1'b1;
      if (i_send) begin
        o_service_in <= 1'b1;
        o_bus_in <= i_byte;
      end
      // Byte and service_in stand until the channel answers.
      if (o_service_in && (i_service_out || i_command_out)) begin
        o_service_in <= 1'b0;
        o_bus_in <= ~o_bus_in;
        stop_r <= i_command_out;
      end
      // Stacked status drops, then comes back once command_out falls.
      if (o_status_in && i_command_out) begin
        o_status_in <= 1'b0;
        stop_r <= 1'b1;
      end
      // Ending starts as soon as the answer drops.
      // A one-ending unit: channel end and device end go at once, unsuppressed.
      if (stop_r && !i_command_out && !o_status_in) begin
        o_status_in <= 1'b1;
        stop_r <= 1'b0;
      end
      // Accept drops status, then operational_in.
      if (o_status_in && i_service_out) begin
        o_status_in <= 1'b0;
        o_chain <= i_suppress_out;
        acc_r <= 1'b1;
      end
      if (acc_r) o_operational_in <= 1'b0;
      // Disconnect or selective reset clears the unit.
      // No device end is held, so no busy state is left.
      if (gap_r >= 10'h019 || (i_suppress_out && !i_operational_out)) begin
        {o_operational_in, o_status_in, o_service_in, stop_r} <= 4'h0;
      end
      if (rst_r >= 10'h258) begin
        {o_operational_in, o_status_in, o_service_in, stop_r} <= 4'h0;
        o_sys_rst <= 1'b1;
      end
    end
  end
endmodule : csc_adapter_model

// file: csc_channel_seq.sv
// Purpose: Channel-side tag sequencer for a byte-wide selector channel.
// Assumes: Processor commands are one-cycle pulses, taken while
//   o_cmd_ready is high; adapter tag lines are asynchronous.
// Notes: Selection and ending are driven by processor commands; timed gaps
//   come from one shared down-counter.
// Behaviour
// - Suppress_out high when service_out answers status signals chaining.
// - Disconnect: address_out high, select and hold low for 250 ns.
// - Adapter drops operational_in; channel then drops address_out.
// - Selective reset: raise suppress_out, then drop operational_out.
// - System reset: operational_out and suppress_out both low 6 us.
// - Stop answers service_in with command_out; byte is not transferred.
// - Software-stepped diagnostic mode drives every tag line directly.
// - Service_out answers status_in to accept; held until status_in falls.
// - Inbound byte sampled while service_in held, before service_out.
`include "csc_defs.svh"
`timescale 1ns/10ps
module csc_channel_seq
  import csc_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic i_clk,                     // System clock, 100 MHz.
  input wire logic i_reset_n,                 // Async reset, active low.
  input wire logic i_sw_mode,                 // Software-stepped mode.
  input wire logic [`CSC_SW_W-1:0] i_sw_tags, // Tag levels in that mode.
  input wire logic i_selector_mode,           // Selector mode, no stacking.
  input wire logic i_suppress_req,            // Processor wants suppression.
  input wire logic i_cmd_select,              // Pulse: start selection.
  input wire logic i_cmd_accept,              // Pulse: accept status.
  input wire logic i_cmd_chain,               // Level with accept: chaining.
  input wire logic i_cmd_stack,               // Pulse: stack status.
  input wire logic i_cmd_stop,                // Pulse: stop the transfer.
  input wire logic i_cmd_disc,                // Pulse: interface disconnect.
  input wire logic i_cmd_sel_reset,           // Pulse: selective reset.
  input wire logic i_cmd_sys_reset,           // Pulse: system reset.
  input wire logic [DATA_W-1:0] i_out_data,   // Next outbound byte.
  input wire logic i_operational_in,          // Adapter operational_in.
  input wire logic i_status_in,               // Adapter status_in.
  input wire logic i_service_in,              // Adapter service_in.
  input wire logic [DATA_W-1:0] i_bus_in,     // Inbound bus.
  output logic o_operational_out,             // Channel enable tag.
  output logic o_suppress_out,                // Suppress tag.
  output logic o_address_out,                 // Address tag.
  output logic o_select_out,                  // Select tag.
  output logic o_hold_out,                    // Hold tag.
  output logic o_service_out,                 // Service tag.
  output logic o_command_out,                 // Command tag.
  output logic [DATA_W-1:0] o_bus_out,        // Outbound bus.
  output logic [DATA_W-1:0] o_in_data,        // Last inbound byte.
  output logic o_in_valid,                    // Pulse: byte captured.
  output logic o_status_pend,                 // Status waits for answer.
  output logic o_cmd_ready                    // Commands may be given.
);

  localparam logic [`CSC_TMR_W-1:0] GAP_CYC = `CSC_TMR_W'(`CSC_GAP_CYC);
  localparam logic [`CSC_TMR_W-1:0] RST_CYC = `CSC_TMR_W'(`CSC_RESET_CYC);

  logic [`CSC_IN_W-1:0] tags_in;
  logic operational_in;
  logic stat_in;
  logic service_in;

  //////////////////////////////////////////////////////////////////////////
  // Inbound tags are synchronised before the sequencer looks at them.
  csc_sync #(
    .WIDTH(`CSC_IN_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_service_in, i_status_in, i_operational_in}),
    .o_sync(tags_in)
  );

  assign operational_in = tags_in[`CSC_IN_OPL];
  assign stat_in = tags_in[`CSC_IN_STAT];
  assign service_in = tags_in[`CSC_IN_SRV];

  csc_state_t state_r, state_nxt;
  logic [`CSC_TMR_W-1:0] tmr_r, tmr_nxt;
  logic sel_r, sel_nxt;
  logic adr_r, adr_nxt;
  logic sup_r, sup_nxt;
  logic opl_r, opl_nxt;
  logic srv_r, srv_nxt;
  logic cmd_r, cmd_nxt;
  logic chain_r, chain_nxt;
  logic stop_r, stop_nxt;
  logic valid_r, valid_nxt;
  logic [DATA_W-1:0] din_r, din_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic tmr_done;

  assign tmr_done = (tmr_r == '0);

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next-state logic. One timer serves every interval because
  // no two timed intervals ever overlap; that keeps the area small.
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_done ? tmr_r : tmr_r - `CSC_TMR_W'(1);
    sel_nxt = sel_r;
    adr_nxt = adr_r;
    sup_nxt = sup_r;
    opl_nxt = opl_r;
    srv_nxt = srv_r;
    cmd_nxt = cmd_r;
    chain_nxt = chain_r;
    stop_nxt = stop_r;
    valid_nxt = 1'b0;
    din_nxt = din_r;
    dout_nxt = dout_r;
    unique case (state_r)
      CSC_IDLE: begin
        opl_nxt = 1'b1;
        sup_nxt = i_suppress_req;
        if (i_cmd_stop) begin
          stop_nxt = 1'b1;
        end
        if (i_cmd_sys_reset) begin
          opl_nxt = 1'b0;
          sup_nxt = 1'b0;
          sel_nxt = 1'b0;
          adr_nxt = 1'b0;
          tmr_nxt = RST_CYC;
          state_nxt = CSC_SYS_RST;
        end else if (i_cmd_sel_reset) begin
          sup_nxt = 1'b1;
          tmr_nxt = GAP_CYC;
          state_nxt = CSC_SR_LEAD;
        end else if (i_cmd_disc && adr_r) begin
          sel_nxt = 1'b0;
          tmr_nxt = GAP_CYC;
          state_nxt = CSC_DISC_WAIT;
        end else if (i_cmd_select && !adr_r) begin
          // Suppression must lead selection, so selection waits for it.
          sup_nxt = i_suppress_req;
          tmr_nxt = i_suppress_req ? GAP_CYC : '0;
          state_nxt = CSC_SEL_LEAD;
        end else if (stat_in && (i_cmd_accept || i_cmd_stack)) begin
          chain_nxt = i_cmd_accept && i_cmd_chain;
          if (i_cmd_stack && !i_selector_mode) begin
            cmd_nxt = 1'b1;
            state_nxt = CSC_STAT_ACK;
          end else if (i_cmd_accept && i_cmd_chain) begin
            sup_nxt = 1'b1;
            tmr_nxt = GAP_CYC;
            state_nxt = CSC_CHAIN_LEAD;
          end else if (i_cmd_accept) begin
            srv_nxt = 1'b1;
            sel_nxt = 1'b0;
            state_nxt = CSC_STAT_ACK;
          end
        end else if (service_in && sel_r && !stat_in) begin
          // Bus is steady while service_in stands, so sample it now.
          if (stop_r || i_cmd_stop) begin
            cmd_nxt = 1'b1;
          end else begin
            din_nxt = i_bus_in;
            valid_nxt = 1'b1;
            dout_nxt = i_out_data;
            srv_nxt = 1'b1;
          end
          state_nxt = CSC_DATA_ACK;
        end
      end
      CSC_SEL_LEAD: begin
        if (tmr_done) begin
          adr_nxt = 1'b1;
          sel_nxt = 1'b1;
          stop_nxt = 1'b0;
          state_nxt = CSC_IDLE;
        end
      end
      CSC_CHAIN_LEAD: begin
        if (tmr_done) begin
          srv_nxt = 1'b1;
          sel_nxt = 1'b0;
          state_nxt = CSC_STAT_ACK;
        end
      end
      CSC_STAT_ACK: begin
        // Suppress stays high through chaining until status_in has gone.
        if (!stat_in) begin
          srv_nxt = 1'b0;
          cmd_nxt = 1'b0;
          sup_nxt = chain_r ? 1'b1 : i_suppress_req;
          chain_nxt = 1'b0;
          if (!sel_r && adr_r && !operational_in) begin
            adr_nxt = 1'b0;
            tmr_nxt = GAP_CYC;
            state_nxt = CSC_ADDR_QUIET;
          end else begin
            state_nxt = CSC_IDLE;
          end
        end
      end
      CSC_DATA_ACK: begin
        // Outbound bus stays put until service_in falls.
        if (!service_in) begin
          srv_nxt = 1'b0;
          cmd_nxt = 1'b0;
          state_nxt = CSC_IDLE;
        end
      end
      CSC_DISC_WAIT: begin
        if (tmr_done) begin
          state_nxt = CSC_DISC_OPL;
        end
      end
      CSC_DISC_OPL: begin
        if (!operational_in) begin
          adr_nxt = 1'b0;
          tmr_nxt = GAP_CYC;
          state_nxt = CSC_ADDR_QUIET;
        end
      end
      CSC_ADDR_QUIET: begin
        if (tmr_done) begin
          state_nxt = CSC_IDLE;
        end
      end
      CSC_SR_LEAD: begin
        if (tmr_done) begin
          opl_nxt = 1'b0;
          sel_nxt = 1'b0;
          adr_nxt = 1'b0;
          tmr_nxt = RST_CYC;
          state_nxt = CSC_SR_LOW;
        end
      end
      CSC_SR_LOW: begin
        // Released only once both the minimum and the answer are in.
        if (tmr_done && !operational_in) begin
          opl_nxt = 1'b1;
          tmr_nxt = GAP_CYC;
          state_nxt = CSC_SR_TAIL;
        end
      end
      CSC_SR_TAIL: begin
        if (tmr_done) begin
          sup_nxt = i_suppress_req;
          stop_nxt = 1'b0;
          state_nxt = CSC_IDLE;
        end
      end
      CSC_SYS_RST: begin
        if (tmr_done) begin
          opl_nxt = 1'b1;
          stop_nxt = 1'b0;
          state_nxt = CSC_IDLE;
        end
      end
    endcase
    // Diagnostic stepping parks the sequencer and clears its requests.
    if (i_sw_mode) begin
      state_nxt = CSC_IDLE;
      srv_nxt = 1'b0;
      cmd_nxt = 1'b0;
      chain_nxt = 1'b0;
      sel_nxt = 1'b0;
      adr_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= CSC_IDLE;
      tmr_r <= '0;
      sel_r <= 1'b0;
      adr_r <= 1'b0;
      sup_r <= 1'b0;
      opl_r <= 1'b0;
      srv_r <= 1'b0;
      cmd_r <= 1'b0;
      chain_r <= 1'b0;
      stop_r <= 1'b0;
      valid_r <= 1'b0;
      din_r <= '0;
      dout_r <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      sel_r <= sel_nxt;
      adr_r <= adr_nxt;
      sup_r <= sup_nxt;
      opl_r <= opl_nxt;
      srv_r <= srv_nxt;
      cmd_r <= cmd_nxt;
      chain_r <= chain_nxt;
      stop_r <= stop_nxt;
      valid_r <= valid_nxt;
      din_r <= din_nxt;
      dout_r <= dout_nxt;
    end
  end

  logic [`CSC_SW_W-1:0] sw_r, sw_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Software-stepped tag levels are registered so outputs stay glitch free.
  always_comb begin
    sw_nxt = i_sw_tags;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sw_r <= '0;
    end else begin
      sw_r <= sw_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Tag outputs: software levels in diagnostic mode, sequencer otherwise.
  // The mode switch itself may glitch tags, so change it only when idle.
  assign o_operational_out = i_sw_mode ? sw_r[`CSC_SW_OPL] : opl_r;
  assign o_suppress_out = i_sw_mode ? sw_r[`CSC_SW_SUP] : sup_r;
  assign o_address_out = i_sw_mode ? sw_r[`CSC_SW_ADR] : adr_r;
  assign o_select_out = i_sw_mode ? sw_r[`CSC_SW_SEL] : sel_r;
  assign o_hold_out = i_sw_mode ? sw_r[`CSC_SW_HLD] : sel_r;
  assign o_service_out = i_sw_mode ? sw_r[`CSC_SW_SRV] : srv_r;
  assign o_command_out = i_sw_mode ? sw_r[`CSC_SW_CMD] : cmd_r;
  assign o_bus_out = dout_r;
  assign o_in_data = din_r;
  assign o_in_valid = valid_r;
  assign o_status_pend = stat_in && (state_r == CSC_IDLE) && !i_sw_mode;
  assign o_cmd_ready = (state_r == CSC_IDLE) && !i_sw_mode;

endmodule : csc_channel_seq

// file: csc_defs.svh
// Purpose: Timing and bit-position constants for the channel sequencer.
// Assumes: A 10 ns system clock.
// Notes: Cycle counts are derived from the printed times, rounded up.
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

`define CSC_CLK_NS 10
`define CSC_T_GAP_NS 250
`define CSC_T_RESET_NS 6000
// A least time rounds up to whole cycles.
`define CSC_GAP_CYC ((`CSC_T_GAP_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`define CSC_RESET_CYC ((`CSC_T_RESET_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`define CSC_TMR_W 10
// Bit positions of the software-stepped tag vector.
`define CSC_SW_W 7
`define CSC_SW_OPL 0
`define CSC_SW_SUP 1
`define CSC_SW_ADR 2
`define CSC_SW_SEL 3
`define CSC_SW_HLD 4
`define CSC_SW_SRV 5
`define CSC_SW_CMD 6
// Bit positions inside the inbound tag synchroniser.
`define CSC_IN_W 3
`define CSC_IN_OPL 0
`define CSC_IN_STAT 1
`define CSC_IN_SRV 2

`endif

// file: csc_pkg.sv
// Purpose: Types shared by the channel sequencer files.
// Assumes: Nothing beyond the constants header.
// Notes: States are listed in sequence order for readability.
package csc_pkg;

  typedef enum logic [3:0] {
    CSC_IDLE,
    CSC_SEL_LEAD,
    CSC_CHAIN_LEAD,
    CSC_STAT_ACK,
    CSC_DATA_ACK,
    CSC_DISC_WAIT,
    CSC_DISC_OPL,
    CSC_ADDR_QUIET,
    CSC_SR_LEAD,
    CSC_SR_LOW,
    CSC_SR_TAIL,
    CSC_SYS_RST
  } csc_state_t;

endpackage : csc_pkg

// file: csc_seq_monitor.sv
// Purpose: Tag-line timing checks on the channel sequencer ports.
// Assumes: 100 MHz clock, so the gap is 25 and the reset 600 cycles.
// Notes: Software-stepped mode is left out of every check.
`include "csc_defs.svh"
`timescale 1ns/10ps
module csc_seq_monitor (
  input wire logic i_clk,             // Clock.
  input wire logic i_reset_n,         // Reset, active low.
  input wire logic i_sw_mode,         // Stepped mode.
  input wire logic i_operational_in,  // Adapter tag.
  input wire logic i_status_in,       // Adapter tag.
  input wire logic i_service_in,      // Adapter tag.
  input wire logic o_operational_out, // Channel tag.
  input wire logic o_suppress_out,    // Channel tag.
  input wire logic o_address_out,     // Channel tag.
  input wire logic o_select_out,      // Channel tag.
  input wire logic o_service_out      // Channel tag.
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int RST_M1 = `CSC_RESET_CYC - 1;
  localparam int GAP_M1 = `CSC_GAP_CYC - 1;
  logic [9:0] low_r, low_nxt, aq_r, aq_nxt;
  logic seen_r, seen_nxt;
  // Low-time counters; the address counter starts full since reset is quiet.
  always_comb begin
    low_nxt = o_operational_out ? 10'h000 : low_r + 10'h001;
    aq_nxt = o_address_out ? 10'h000 : aq_r + {9'h000, aq_r != 10'h3ff};
    seen_nxt = seen_r | o_operational_out;
  end
  // The first rise after reset is no reset release, so seen_r masks it.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_r <= 10'h000;
      aq_r <= 10'h3ff;
      seen_r <= 1'b0;
    end else begin
      low_r <= low_nxt;
      aq_r <= aq_nxt;
      seen_r <= seen_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  AST_SUP_LEAD_SEL: assert property (
    $rose(o_select_out) && o_suppress_out && !i_sw_mode
    |-> $past(o_suppress_out, 25)) else $error("Select lead too short.");
  AST_CHAIN_LEAD: assert property (
    $rose(o_service_out) && o_suppress_out && !i_sw_mode
    |-> $past(o_suppress_out, 25)) else $error("Chain lead too short.");
  AST_CHAIN_HOLD: assert property (
    o_service_out && o_suppress_out && i_status_in && !i_sw_mode
    |=> o_suppress_out) else $error("Suppress dropped before status.");
  AST_SRV_CAUSE: assert property (
    $rose(o_service_out) && !i_sw_mode
    |-> $past(i_service_in, 2) || $past(i_status_in, 2))
    else $error("Service out without a synced cause.");
  AST_SR_LOW_TIME: assert property (
    $rose(o_operational_out) && o_suppress_out && seen_r && !i_sw_mode
    |-> low_r >= RST_M1 && !$past(i_operational_in, 2))
    else $error("Selective reset too short.");
  AST_SR_SUP_LEAD: assert property (
    $fell(o_operational_out) && o_suppress_out && !i_sw_mode
    |-> $past(o_suppress_out, 25)) else $error("Reset lead too short.");
  AST_SR_SUP_TAIL: assert property (
    $rose(o_operational_out) && o_suppress_out && seen_r && !i_sw_mode
    |-> o_suppress_out throughout (##24 1'b1))
    else $error("Reset tail too short.");
  AST_SYS_LOW_TIME: assert property (
    $rose(o_operational_out) && !o_suppress_out && seen_r && !i_sw_mode
    |-> low_r >= RST_M1) else $error("System reset too short.");
  AST_ADDR_QUIET: assert property (
    $rose(o_address_out) && !i_sw_mode |-> aq_r >= GAP_M1)
    else $error("Address quiet gap too short.");
  AST_DISC_ORDER: assert property (
    $fell(o_address_out) && o_operational_out && !i_sw_mode
    |-> !$past(i_operational_in, 2)) else $error("Address dropped early.");
endmodule : csc_seq_monitor

bind csc_channel_seq csc_seq_monitor u_mon (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sw_mode(i_sw_mode),
  .i_operational_in(i_operational_in), .i_status_in(i_status_in),
  .i_service_in(i_service_in), .o_operational_out(o_operational_out),
  .o_suppress_out(o_suppress_out), .o_address_out(o_address_out),
  .o_select_out(o_select_out), .o_service_out(o_service_out)
);

// file: csc_sync.sv
// Purpose: Two-stage synchroniser for the inbound tag lines.
// Assumes: Inputs may change at any time relative to i_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/10ps
module csc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic i_clk,               // System clock.
  input wire logic i_reset_n,           // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] i_async, // Raw inbound levels.
  output logic [WIDTH-1:0] o_sync       // Synchronised levels.
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  //////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second, to give metastability a cycle.
  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule : csc_sync

// file: test_channel_sequence_controls.sv
// Purpose: Self-checking bench for the channel sequencer.
// Assumes: Inputs change at the falling edge; adapter is modelled.
// Notes: Long waits are cut short by a cycle watchdog.
`timescale 1ns/10ps
module test_channel_sequence_controls;
  logic i_clk, i_reset_n, sw_mode, sel_mode, sup_req, send, c_sel, c_acc;
  logic c_chain, c_stack, c_stop, c_disc, c_sr, c_sys;
  logic [6:0] sw_tags;
  logic [7:0] byte_v, bus_out, in_data, bus_in, out_v;
  logic op_out, suppress_out, adr_out, sel_out, hold_out, service_out, cmd_out;
  logic in_valid, st_pend, ready, op_in, st_in, service_in, chain, sys_rst;
  int failures, checked, cycles, n;
  ////////////////////////////////////////////////////////////////////////////
  csc_channel_seq uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_sw_mode(sw_mode), .i_sw_tags(sw_tags), .i_selector_mode(sel_mode),
    .i_suppress_req(sup_req), .i_cmd_select(c_sel), .i_cmd_accept(c_acc),
    .i_cmd_chain(c_chain), .i_cmd_stack(c_stack), .i_cmd_stop(c_stop),
    .i_cmd_disc(c_disc), .i_cmd_sel_reset(c_sr), .i_cmd_sys_reset(c_sys),
    .i_out_data(out_v), .i_operational_in(op_in), .i_status_in(st_in),
    .i_service_in(service_in), .i_bus_in(bus_in), .o_operational_out(op_out),
    .o_suppress_out(suppress_out), .o_address_out(adr_out),
    .o_select_out(sel_out), .o_hold_out(hold_out), .o_service_out(service_out),
    .o_command_out(cmd_out), .o_bus_out(bus_out), .o_in_data(in_data),
    .o_in_valid(in_valid), .o_status_pend(st_pend), .o_cmd_ready(ready));
  csc_adapter_model u_adp (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_send(send), .i_byte(byte_v), .i_operational_out(op_out),
    .i_suppress_out(suppress_out), .i_address_out(adr_out),
    .i_select_out(sel_out), .i_hold_out(hold_out), .i_service_out(service_out),
    .i_command_out(cmd_out), .o_operational_in(op_in), .o_status_in(st_in),
    .o_service_in(service_in), .o_bus_in(bus_in), .o_chain(chain),
    .o_sys_rst(sys_rst));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a watchdog so a stuck handshake still ends the run.
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      final_report();
    end
  end
  task final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task step();
    @(negedge i_clk);
  endtask : step
  // Commands are only taken while ready, so wait for it first.
  task automatic pulse(ref logic s);
    while (ready !== 1'b1) step();
    s = 1'b1;
    step();
    s = 1'b0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  task t_select(input logic sup);
    sup_req = sup;
    repeat (3) step();
    pulse(c_sel);
    while (sel_out !== 1'b1) step();
    repeat (4) step();
    check("op_in", 8'(op_in), 8'h01);
  endtask : t_select
  // Two bytes back to back, each held until the answer.
  task t_data();
    for (int i = 0; i < 2; i++) begin
      byte_v = i[0] ? 8'ha5 : 8'h5a;
      out_v = ~byte_v;
      send = 1'b1;
      step();
      send = 1'b0;
      while (in_valid !== 1'b1) step();
      check("in_data", in_data, byte_v);
      check("bus_out", bus_out, out_v);
      while (service_out !== 1'b0) step();
    end
  endtask : t_data
  task t_stop();
    n = 0;
    pulse(c_stop);
    byte_v = 8'h3c;
    send = 1'b1;
    step();
    send = 1'b0;
    while (st_pend !== 1'b1) begin
      n += int'(in_valid === 1'b1);
      step();
    end
    check("stop bytes", 8'(n), 8'h00);
    check("stop status", 8'(st_in), 8'h01);
  endtask : t_stop
  task t_stack();
    sel_mode = 1'b1;
    pulse(c_stack);
    repeat (10) step();
    check("stack answer", 8'({cmd_out, service_out}), 8'h00);
    sel_mode = 1'b0;
    // Outside selector mode the stack answer is command_out, not service.
    pulse(c_stack);
    check("stack cmd", 8'({cmd_out, service_out}), 8'h02);
    while (st_pend !== 1'b1) step();
  endtask : t_stack
  task t_accept();
    c_chain = 1'b1;
    pulse(c_acc);
    c_chain = 1'b0;
    while (op_in !== 1'b0) step();
    check("chain", 8'(chain), 8'h01);
  endtask : t_accept
  task t_disc();
    pulse(c_disc);
    while (adr_out !== 1'b0) step();
    check("disc tags", 8'({op_in, st_in, service_in}), 8'h00);
  endtask : t_disc
  // Low time counted here, whether the unit dropped first or not.
  task t_reset_op(input logic sel, input logic exp_sys);
    if (sel) pulse(c_sr);
    else pulse(c_sys);
    while (op_out !== 1'b0) step();
    n = 0;
    while (op_out !== 1'b1) begin
      step();
      n++;
    end
    check("low time", 8'(n >= 600), 8'h01);
    check("unit reset", 8'({op_in, sys_rst}), {7'h00, exp_sys});
    repeat (30) step();
  endtask : t_reset_op
  task t_sw();
    sw_mode = 1'b1;
    sw_tags = 7'h55;
    repeat (3) step();
    check("sw tags", 8'({cmd_out, service_out, hold_out, sel_out, adr_out,
      suppress_out, op_out}), 8'h55);
    check("sw ready", 8'(ready), 8'h00);
  endtask : t_sw
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_clk, i_reset_n, sw_mode, sel_mode, sup_req, send, c_sel} = 7'h00;
    {c_acc, c_chain, c_stack, c_stop, c_disc, c_sr, c_sys} = 7'h00;
    {sw_tags, byte_v, out_v} = 23'h000000;
    {failures, checked, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (8) step();
    check("op_out in reset", 8'(op_out), 8'h00);
    i_reset_n = 1'b1;
    step();
    check("op_out idle", 8'(op_out), 8'h01);
    t_select(1'b1);
    t_data();
    t_stop();
    t_stack();
    t_accept();
    t_disc();
    t_select(1'b0);
    t_disc();
    t_select(1'b0);
    t_reset_op(1'b1, 1'b0);
    sup_req = 1'b0;
    t_reset_op(1'b0, 1'b1);
    t_sw();
    final_report();
  end
endmodule : test_channel_sequence_controls
